/* File: inc/pech_regs.svh */
/*
 * Register offsets, field positions, reset values and timing counts of the
 * performance event counter and history block.
 * Assumes an APB slave with an 8-bit byte address and 32-bit data.
 */
`ifndef PECH_REGS_SVH
`define PECH_REGS_SVH

// ----------------------------------------------------------------------
// Register byte addresses, word region 0
// ----------------------------------------------------------------------
`define PECH_A_CTRL 8'h00
`define PECH_A_BLOCKS 8'h04
`define PECH_A_CMD 8'h08
`define PECH_A_STATUS 8'h0c
`define PECH_A_HSEL 8'h10
`define PECH_W_LAST_CTRL 4'h4

// ----------------------------------------------------------------------
// Address regions, 16 words each
// ----------------------------------------------------------------------
`define PECH_RG_CTRL 2'h0
`define PECH_RG_CUR 2'h1
`define PECH_RG_HIST 2'h2
`define PECH_RG_LOG 2'h3
`define PECH_W_STAMP 3'h6
`define PECH_W_SUSP 3'h7
`define PECH_NUM_CNT 3'h6

// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define PECH_CTRL_SKIP 0
`define PECH_CMD_CLR15 0
`define PECH_CMD_CLR24 8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PECH_BLOCKS_RST 16'h1f40
`define PECH_SUSP_RST 2'h3

// ----------------------------------------------------------------------
// Timing counts in one-second strobes, quarter count in quarters, severe-second ratio
// ----------------------------------------------------------------------
`define PECH_SEC_LAST 10'h383
`define PECH_QTR_LAST 7'h5f
`define PECH_RUN_LEN 4'ha
`define PECH_WIN_LAST 9
`define PECH_SEV_NUM 20'h00003
`define PECH_SEV_DEN 20'h0000a

`endif

/* File: inc/pech_pkg.sv */
/*
 * Types of the performance event counter and history block.
 * Assumes the constants of pech_regs.svh for all figures.
 */
package pech_pkg;

    // One buffered second of one direction
    typedef struct packed {
        logic avail;
        logic errored;
        logic severe;
        logic [15:0] background;
    } pech_sec_t;

    // Whole block state
    typedef struct packed {
        logic [9:0] sec_cnt;
        logic [6:0] qtr_cnt;
        logic stamp_ok;
        logic [29:0] stamp15;
        logic [29:0] stamp24;
        logic [5:0][31:0] cur15;
        logic [5:0][31:0] cur24;
        logic [1:0] susp15;
        logic [1:0] susp24;
        logic [15:0][5:0][31:0] hist15;
        logic [15:0][29:0] hstamp15;
        logic [15:0][1:0] hsusp15;
        logic [3:0] hist_head;
        logic [5:0][31:0] day;
        logic [29:0] dstamp;
        logic [1:0] dsusp;
        pech_sec_t [1:0][9:0] win;
        logic [1:0] unavail;
        logic [1:0][3:0] run;
        logic [15:0][31:0] ulog;
        logic [3:0] log_head;
        logic [4:0] log_cnt;
        logic [15:0] seq;
        logic skip_zero;
        logic [15:0] blocks;
        logic [3:0] hsel;
        logic near_errored;
        logic near_severe;
        logic far_errored;
        logic far_severe;
        logic [15:0] near_background;
        logic [15:0] far_background;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } pech_state_t;

endpackage

/* File: design/pech_top.sv */
/*
 * Per-second performance event derivation, 15-minute and 24-hour counting,
 * availability tracking, unavailability log and history, with APB access.
 * Assumes per-second monitor results that are valid while SEC_STROBE_I is
 * high for one cycle, and a time-of-day value steady around each strobe.
 */
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "pech_regs.svh"

module pech_top (
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    input wire logic CE_I,
    input wire logic SEC_STROBE_I,
    input wire logic NEAR_DEFECT_SECOND_I,
    input wire logic FAR_DEFECT_SECOND_I,
    input wire logic [15:0] NEAR_ERRORED_BLOCK_COUNT_I,
    input wire logic [15:0] FAR_ERRORED_BLOCK_COUNT_I,
    input wire logic [29:0] TOD_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic NEAR_ERRORED_SECOND_O,
    output logic NEAR_SEVERE_SECOND_O,
    output logic FAR_ERRORED_SECOND_O,
    output logic FAR_SEVERE_SECOND_O,
    output logic [15:0] NEAR_BACKGROUND_BLOCK_ERRORS_O,
    output logic [15:0] FAR_BACKGROUND_BLOCK_ERRORS_O,
    output logic NEAR_UNAVAILABLE_O,
    output logic FAR_UNAVAILABLE_O
);

    pech_pkg::pech_state_t s;
    pech_pkg::pech_state_t next_s;
    pech_pkg::pech_sec_t new_sec [1:0];
    pech_pkg::pech_sec_t pop;
    logic [19:0] thr;
    logic near_sev;
    logic far_sev;
    logic boundary;
    logic day_end;
    logic wr;
    logic hit;
    logic [31:0] rdata;
    logic [3:0] hidx;
    logic [1:0] region;
    logic [3:0] word;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_s = s;
        thr = s.blocks * `PECH_SEV_NUM;
        near_sev = 1'b0;
        far_sev = 1'b0;
        boundary = 1'b0;
        day_end = 1'b0;
        wr = 1'b0;
        hit = 1'b1;
        rdata = 32'h0000_0000;
        pop = '0;
        new_sec[0] = '0;
        new_sec[1] = '0;
        hidx = s.hist_head - s.hsel;
        region = PADDR_I[7:6];
        word = PADDR_I[5:2];

        // Read mux; a read only selects, it never changes state
        unique case (region)
            `PECH_RG_CTRL: begin
                unique case (word)
                    4'h0: rdata = {31'h0, s.skip_zero};
                    4'h1: rdata = {16'h0000, s.blocks};
                    4'h2: rdata = 32'h0000_0000;
                    4'h3: rdata = {s.seq, 3'h0, s.log_cnt, 6'h00, s.unavail};
                    4'h4: rdata = {28'h0, s.hsel};
                    default: hit = 1'b0;
                endcase
            end
            `PECH_RG_CUR: begin
                if (word[2:0] < `PECH_NUM_CNT) begin
                    rdata = word[3] ? s.cur24[word[2:0]] : s.cur15[word[2:0]];
                end else if (word[2:0] == `PECH_W_STAMP) begin
                    rdata = {2'h0, word[3] ? s.stamp24 : s.stamp15};
                end else begin
                    rdata = {30'h0, word[3] ? s.susp24 : s.susp15};
                end
            end
            `PECH_RG_HIST: begin
                if (word[2:0] < `PECH_NUM_CNT) begin
                    rdata = word[3] ? s.day[word[2:0]] : s.hist15[hidx][word[2:0]];
                end else if (word[2:0] == `PECH_W_STAMP) begin
                    rdata = {2'h0, word[3] ? s.dstamp : s.hstamp15[hidx]};
                end else begin
                    rdata = {30'h0, word[3] ? s.dsusp : s.hsusp15[hidx]};
                end
            end
            `PECH_RG_LOG: rdata = s.ulog[word];
        endcase

        if (CE_I) begin
            // APB: answer registered in setup, ready in first access cycle
            next_s.pready = 1'b0;
            next_s.pslverr = 1'b0;
            if (PSEL_I && !PENABLE_I) begin
                next_s.pready = 1'b1;
                next_s.pslverr = ~hit;
                next_s.prdata = hit ? rdata : 32'h0000_0000;
            end
            wr = PSEL_I && PENABLE_I && PWRITE_I && s.pready && !s.pslverr;

            // Per-second derivation on the monitor strobe
            if (SEC_STROBE_I) begin
                near_sev = NEAR_DEFECT_SECOND_I ||
                    ({4'h0, NEAR_ERRORED_BLOCK_COUNT_I} * `PECH_SEV_DEN >= thr);
                far_sev = FAR_DEFECT_SECOND_I ||
                    ({4'h0, FAR_ERRORED_BLOCK_COUNT_I} * `PECH_SEV_DEN >= thr);
                next_s.near_errored = NEAR_DEFECT_SECOND_I ||
                    (NEAR_ERRORED_BLOCK_COUNT_I != 16'h0000);
                next_s.near_severe = near_sev;
                next_s.near_background = near_sev ? 16'h0000 : NEAR_ERRORED_BLOCK_COUNT_I;
                next_s.far_errored = !NEAR_DEFECT_SECOND_I && (FAR_DEFECT_SECOND_I ||
                    (FAR_ERRORED_BLOCK_COUNT_I != 16'h0000));
                next_s.far_severe = !NEAR_DEFECT_SECOND_I && far_sev;
                next_s.far_background = (far_sev || NEAR_DEFECT_SECOND_I) ?
                    16'h0000 : FAR_ERRORED_BLOCK_COUNT_I;
                new_sec[0] = '{avail: !s.unavail[0], errored: next_s.near_errored,
                    severe: next_s.near_severe, background: next_s.near_background};
                new_sec[1] = '{avail: !s.unavail[1], errored: next_s.far_errored,
                    severe: next_s.far_severe, background: next_s.far_background};

                // First strobe after reset opens both stamped intervals
                if (!s.stamp_ok) begin
                    next_s.stamp_ok = 1'b1;
                    next_s.stamp15 = TOD_I;
                    next_s.stamp24 = TOD_I;
                end

                // Per direction: delay line, availability, counting
                for (int d = 0; d < 2; d++) begin
                    pop = s.win[d][`PECH_WIN_LAST];
                    for (int j = `PECH_WIN_LAST; j > 0; j--) begin
                        next_s.win[d][j] = s.win[d][j-1];
                    end
                    next_s.win[d][0] = new_sec[d];
                    // Run of seconds opposing the current state
                    if (new_sec[d].severe == s.unavail[d]) begin
                        next_s.run[d] = 4'h0;
                    end else if (s.run[d] + 4'h1 == `PECH_RUN_LEN) begin
                        // Whole run held in the window is reclassified
                        next_s.run[d] = 4'h0;
                        next_s.unavail[d] = ~s.unavail[d];
                        for (int j = 0; j <= `PECH_WIN_LAST; j++) begin
                            next_s.win[d][j].avail = s.unavail[d];
                        end
                        // Log entry: direction, end flag, stamp
                        // Both directions may flip on one strobe: chain on next_s
                        next_s.ulog[next_s.log_head] = {d[0], s.unavail[d], TOD_I};
                        next_s.log_head = next_s.log_head + 4'h1;
                        if (next_s.log_cnt != 5'h10) begin
                            next_s.log_cnt = next_s.log_cnt + 5'h01;
                        end
                    end else begin
                        next_s.run[d] = s.run[d] + 4'h1;
                    end
                    // Oldest second counted only with its final class
                    if (pop.avail) begin
                        next_s.cur15[d*3] = s.cur15[d*3] + {16'h0000, pop.background};
                        next_s.cur15[d*3+1] = s.cur15[d*3+1] + {31'h0, pop.errored};
                        next_s.cur15[d*3+2] = s.cur15[d*3+2] + {31'h0, pop.severe};
                        next_s.cur24[d*3] = s.cur24[d*3] + {16'h0000, pop.background};
                        next_s.cur24[d*3+1] = s.cur24[d*3+1] + {31'h0, pop.errored};
                        next_s.cur24[d*3+2] = s.cur24[d*3+2] + {31'h0, pop.severe};
                    end
                end

                // Interval boundaries counted in strobes
                if (s.sec_cnt == `PECH_SEC_LAST) begin
                    next_s.sec_cnt = 10'h000;
                    boundary = 1'b1;
                    if (s.qtr_cnt == `PECH_QTR_LAST) begin
                        next_s.qtr_cnt = 7'h00;
                        day_end = 1'b1;
                    end else begin
                        next_s.qtr_cnt = s.qtr_cnt + 7'h01;
                    end
                end else begin
                    next_s.sec_cnt = s.sec_cnt + 10'h001;
                end
            end

            // Quarter push; all-zero interval may be skipped
            if (boundary) begin
                if (!(s.skip_zero && next_s.cur15 == '0 && s.susp15 == 2'h0)) begin
                    next_s.hist_head = s.hist_head + 4'h1;
                    next_s.hist15[s.hist_head + 4'h1] = next_s.cur15;
                    next_s.hstamp15[s.hist_head + 4'h1] = s.stamp15;
                    next_s.hsusp15[s.hist_head + 4'h1] = s.susp15;
                end
                next_s.seq = s.seq + 16'h0001;
                next_s.cur15 = '0;
                next_s.susp15 = 2'h0;
                next_s.stamp15 = TOD_I;
            end
            // Daily push overwrites the single entry
            if (day_end) begin
                next_s.day = next_s.cur24;
                next_s.dstamp = s.stamp24;
                next_s.dsusp = s.susp24;
                next_s.cur24 = '0;
                next_s.susp24 = 2'h0;
                next_s.stamp24 = TOD_I;
            end

            // Register writes
            if (wr) begin
                unique case (PADDR_I)
                    `PECH_A_CTRL: next_s.skip_zero = PWDATA_I[`PECH_CTRL_SKIP];
                    `PECH_A_BLOCKS: next_s.blocks = PWDATA_I[15:0];
                    `PECH_A_HSEL: next_s.hsel = PWDATA_I[3:0];
                    `PECH_A_CMD: begin
                        // Clear after the push; clearing taints the side
                        for (int i = 0; i < 6; i++) begin
                            if (PWDATA_I[`PECH_CMD_CLR15 + i]) begin
                                next_s.cur15[i] = 32'h0000_0000;
                                next_s.susp15[i/3] = 1'b1;
                            end
                            if (PWDATA_I[`PECH_CMD_CLR24 + i]) begin
                                next_s.cur24[i] = 32'h0000_0000;
                                next_s.susp24[i/3] = 1'b1;
                            end
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // State register; first intervals are partial, hence suspect
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            s <= '0;
            s.blocks <= `PECH_BLOCKS_RST;
            s.susp15 <= `PECH_SUSP_RST;
            s.susp24 <= `PECH_SUSP_RST;
            for (int d = 0; d < 2; d++) begin
                for (int j = 0; j <= `PECH_WIN_LAST; j++) begin
                    s.win[d][j].avail <= 1'b1;
                end
            end
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from state
    assign PRDATA_O = s.prdata;
    assign PREADY_O = s.pready;
    assign PSLVERR_O = s.pslverr;
    assign NEAR_ERRORED_SECOND_O = s.near_errored;
    assign NEAR_SEVERE_SECOND_O = s.near_severe;
    assign FAR_ERRORED_SECOND_O = s.far_errored;
    assign FAR_SEVERE_SECOND_O = s.far_severe;
    assign NEAR_BACKGROUND_BLOCK_ERRORS_O = s.near_background;
    assign FAR_BACKGROUND_BLOCK_ERRORS_O = s.far_background;
    assign NEAR_UNAVAILABLE_O = s.unavail[0];
    assign FAR_UNAVAILABLE_O = s.unavail[1];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_far_errored: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (CE_I && SEC_STROBE_I) |=> FAR_ERRORED_SECOND_O == (!$past(NEAR_DEFECT_SECOND_I)
        && ($past(FAR_DEFECT_SECOND_I) || $past(FAR_ERRORED_BLOCK_COUNT_I) != 16'h0000)))
        else $error("far errored second wrong");
    a_far_severe_defect: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (CE_I && SEC_STROBE_I && NEAR_DEFECT_SECOND_I) |=> !FAR_SEVERE_SECOND_O)
        else $error("far severe second during near defect");
    a_far_background: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (CE_I && SEC_STROBE_I) |=> FAR_BACKGROUND_BLOCK_ERRORS_O ==
        ((FAR_SEVERE_SECOND_O || $past(NEAR_DEFECT_SECOND_I)) ? 16'h0000 :
        $past(FAR_ERRORED_BLOCK_COUNT_I)))
        else $error("far background errors wrong");
    a_near_errored: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (CE_I && SEC_STROBE_I) |=> NEAR_ERRORED_SECOND_O == ($past(NEAR_DEFECT_SECOND_I)
        || $past(NEAR_ERRORED_BLOCK_COUNT_I) != 16'h0000))
        else $error("near errored second wrong");
    a_near_severe: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (CE_I && SEC_STROBE_I) |=> NEAR_SEVERE_SECOND_O == ($past(NEAR_DEFECT_SECOND_I) ||
        {4'h0, $past(NEAR_ERRORED_BLOCK_COUNT_I)} * 20'h0000a >=
        {4'h0, $past(s.blocks)} * 20'h00003))
        else $error("near severe second wrong");
    a_near_background: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (CE_I && SEC_STROBE_I) |=> NEAR_BACKGROUND_BLOCK_ERRORS_O ==
        (NEAR_SEVERE_SECOND_O ? 16'h0000 : $past(NEAR_ERRORED_BLOCK_COUNT_I)))
        else $error("near background errors wrong");
    a_unavail_enter: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        $rose(s.unavail[0]) |-> $past(s.run[0]) == 4'h9 && NEAR_SEVERE_SECOND_O)
        else $error("unavailable entered without ten severe seconds");
    a_avail_return: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        $fell(s.unavail[1]) |-> $past(s.run[1]) == 4'h9 && !FAR_SEVERE_SECOND_O)
        else $error("available entered without ten clean seconds");
    a_clear_cmd: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (CE_I && PSEL_I && PENABLE_I && PWRITE_I && s.pready && PADDR_I == `PECH_A_CMD
        && PWDATA_I[1]) |=> s.cur15[1] == 32'h0000_0000 && s.susp15[0])
        else $error("clear command ignored");
    a_quarter_clear: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (CE_I && SEC_STROBE_I && s.sec_cnt == `PECH_SEC_LAST) |=> s.cur15 == '0
        && s.stamp15 == $past(TOD_I))
        else $error("quarter counters not cleared");
    a_hist_push: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (CE_I && SEC_STROBE_I && s.sec_cnt == `PECH_SEC_LAST && !s.skip_zero) |=>
        s.hist_head == $past(s.hist_head) + 4'h1 && s.seq == $past(s.seq) + 16'h0001)
        else $error("history not pushed");
    a_read_keeps: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (PSEL_I && !PWRITE_I && !SEC_STROBE_I) |=> s.cur15 == $past(s.cur15) &&
        s.hist15 == $past(s.hist15) && s.cur24 == $past(s.cur24))
        else $error("read disturbed stored data");
    a_apb_ready: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (CE_I && PSEL_I && !PENABLE_I) |=> PREADY_O)
        else $error("no ready after setup");

endmodule

/* File: sim/pech_mon.sv */
/* Model of the per-second monitor primitives feeding the block.
   Assumes the bench calls send once per second, never overlapping. */
`timescale 1ns/1ps
module pech_mon (
    input wire logic clk_i,
    output logic stb_o,
    output logic near_def_o,
    output logic far_def_o,
    output logic [15:0] near_cnt_o,
    output logic [15:0] far_cnt_o,
    output logic [29:0] tod_o
);
    // -------
    // Per-second results
    // -------
    initial begin
        {stb_o, near_def_o, far_def_o, near_cnt_o, far_cnt_o, tod_o} = '0;
    end

    // Strobe one cycle; stale results inverted so nothing relies on them
    task automatic send(input logic nd, input logic fd, input logic [15:0] nc,
                        input logic [15:0] fc);
        @(posedge clk_i);
        stb_o <= 1'b1;
        {near_def_o, far_def_o, near_cnt_o, far_cnt_o} <= {nd, fd, nc, fc};
        tod_o <= tod_o + 30'h1; // Stamp counts seconds
        @(posedge clk_i);
        stb_o <= 1'b0;
        {near_def_o, far_def_o, near_cnt_o, far_cnt_o} <= ~{nd, fd, nc, fc};
    endtask
endmodule

/* File: sim/testbench.sv */
/* Bench: APB master, monitor model, reference model of events and counts.
   Assumes pech_top, pech_mon and the map of pech_regs.svh. */
`timescale 1ns/1ps
`include "pech_regs.svh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin fails++; \
    $display("MISMATCH %0s exp %0h got %0h", nm, ex, got); end end
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0] padr = 8'h00;
    logic [31:0] pwd = 32'h0, prd, r;
    logic prdy, perr, e, stb, near_def, far_def, nu, fu, nd, fd;
    logic near_err, near_sev, far_err, far_sev;
    logic [15:0] near_cnt, far_cnt, near_bg, far_bg, nc, fc;
    logic [29:0] tod;
    int fails = 0, cmp_count = 0, cyc = 0, s = 0, m, skp = 0, sus = 1;
    int run[2], un[2], c15[6], c24[6], h15[6], qv[2][$], qa[2][$], lg[$];

    // -------
    // Clock, ceiling, instances
    // -------
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            fails++;
            conclude();
        end
    end
    pech_mon u_mon (.clk_i(clk), .stb_o(stb), .near_def_o(near_def), .far_def_o(far_def),
        .near_cnt_o(near_cnt), .far_cnt_o(far_cnt), .tod_o(tod));
    pech_top u_dut (.SYS_CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .SEC_STROBE_I(stb),
        .NEAR_DEFECT_SECOND_I(near_def), .FAR_DEFECT_SECOND_I(far_def),
        .NEAR_ERRORED_BLOCK_COUNT_I(near_cnt), .FAR_ERRORED_BLOCK_COUNT_I(far_cnt),
        .TOD_I(tod), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr),
        .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
        .NEAR_ERRORED_SECOND_O(near_err), .NEAR_SEVERE_SECOND_O(near_sev),
        .FAR_ERRORED_SECOND_O(far_err), .FAR_SEVERE_SECOND_O(far_sev),
        .NEAR_BACKGROUND_BLOCK_ERRORS_O(near_bg), .FAR_BACKGROUND_BLOCK_ERRORS_O(far_bg),
        .NEAR_UNAVAILABLE_O(nu), .FAR_UNAVAILABLE_O(fu));

    // Master holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rv, output logic ev);
        @(posedge clk);
        {psel, pen, pwr, padr, pwd} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        // No local limit: the bench ceiling ends a hung wait
        do begin
            @(posedge clk);
        end while (prdy !== 1'b1);
        rv = prd;
        ev = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0, r, e);
        `CHK($sformatf("reg %h", a), ex, r)
    endtask

    task automatic chk_cur();
        for (int i = 0; i < 6; i++) begin
            rd(8'h40 + 8'(4 * i), c15[i]);
            rd(8'h60 + 8'(4 * i), c24[i]);
        end
    endtask

    // One second through monitor, design and reference; counts lag ten seconds
    task automatic sec(input logic a, input logic b, input logic [15:0] x,
                       input logic [15:0] y);
        logic ns, fs, sv;
        int ev[2][3];
        int v, nz;
        u_mon.send(a, b, x, y);
        s++;
        ns = a || x * 10 >= 300;
        fs = !a && (b || y * 10 >= 300);
        ev[0] = '{a || x > 0, ns, ns ? 0 : x};
        ev[1] = '{!a && (b || y > 0), fs, fs || a ? 0 : y};
        for (int d = 0; d < 2; d++) begin
            sv = d ? fs : ns;
            run[d] = sv == un[d] ? 0 : run[d] + 1;
            qv[d].push_back(ev[d][2] * 4 + ev[d][1] * 2 + ev[d][0]);
            qa[d].push_back(1 - un[d]);
            if (qv[d].size() > 10) begin
                v = qv[d].pop_front();
                if (qa[d].pop_front() == 1) begin
                    for (int k = 0; k < 3; k++) begin
                        c15[3 * d + k] += k ? v >> (k - 1) & 1 : v >> 2;
                        c24[3 * d + k] += k ? v >> (k - 1) & 1 : v >> 2;
                    end
                end
            end
            if (run[d] == 10) begin // Whole run reclassified
                un[d] = sv;
                run[d] = 0;
                for (int i = 0; i < qa[d].size(); i++) qa[d][i] = 1 - sv;
                lg.push_back({d[0], !sv, tod});
            end
        end
        if (s % 900 == 0) begin
            nz = sus;
            foreach (c15[k]) nz |= c15[k];
            if (!skp || nz != 0) h15 = c15;
            c15 = '{default: 0};
            sus = 0;
        end
        @(negedge clk);
        `CHK("near errored", ev[0][0], near_err)
        `CHK("near severe", ev[0][1], near_sev)
        `CHK("near background", ev[0][2], near_bg)
        `CHK("far errored", ev[1][0], far_err)
        `CHK("far severe", ev[1][1], far_sev)
        `CHK("far background", ev[1][2], far_bg)
        `CHK("near unav", un[0], nu)
        `CHK("far unav", un[1], fu)
    endtask

    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // -------
    // Sequence
    // -------
    initial begin
        void'($urandom(37806));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(`PECH_A_BLOCKS, 32'h1f40);
        apb(1'b1, `PECH_A_BLOCKS, 32'h64, r, e);
        apb(1'b0, 8'h14, 32'h0, r, e);
        `CHK("unmapped err", 1'b1, e)
        // Blocks of one kind each, long enough to swing availability
        for (int b = 0; b < 10; b++) begin
            m = $urandom % 4;
            repeat (15) begin
                nd = m == 1 || m == 3 && $urandom % 8 == 0;
                fd = m == 2 || m == 3 && $urandom % 8 == 0;
                nc = 16'($urandom % (m[0] ? 41 : 30));
                fc = 16'($urandom % (m ? 41 : 30));
                sec(nd, fd, nc, fc);
            end
        end
        // Idle seconds empty the window so counts are final
        repeat (10) sec(1'b0, 1'b0, 16'h0, 16'h0);
        chk_cur();
        rd(`PECH_A_STATUS, (lg.size() > 16 ? 16 : lg.size()) << 8);
        if (lg.size() > 0 && lg.size() <= 16) rd(8'hc0, lg[0]);
        apb(1'b1, `PECH_A_CMD, 32'h1002, r, e);
        c15[1] = 0;
        sus = 1;
        c24[4] = 0;
        chk_cur();
        rd(8'h5c, 32'h3);
        while (s < 900) sec(1'b0, 1'b0, 16'h0, 16'h0);
        for (int i = 0; i < 6; i++) rd(8'h80 + 8'(4 * i), h15[i]);
        rd(8'h98, 32'h1);
        rd(8'h58, 32'h384);
        chk_cur();
        rd(`PECH_A_STATUS, 32'h10000 + ((lg.size() > 16 ? 16 : lg.size()) << 8));
        // Second quarter all zero with skip on: no push, sequence still moves
        apb(1'b1, `PECH_A_CTRL, 32'h1, r, e);
        skp = 1;
        rd(`PECH_A_CTRL, 32'h1);
        while (s < 1800) sec(1'b0, 1'b0, 16'h0, 16'h0);
        for (int i = 0; i < 6; i++) rd(8'h80 + 8'(4 * i), h15[i]);
        rd(8'h98, 32'h1);
        rd(8'h58, 32'h708);
        rd(`PECH_A_STATUS, 32'h20000 + ((lg.size() > 16 ? 16 : lg.size()) << 8));
        conclude();
    end
endmodule
